// ---- logic/clk_ctrl_pkg.sv ----
// Constants for core clock and sample rate control
package clk_ctrl_pkg;
  localparam logic [15:0] ADDR_CLOCK_CFG = 16'h4000;
  localparam logic [15:0] ADDR_PLL_CFG = 16'h4002;
  localparam logic [15:0] ADDR_CONV_CFG = 16'h4017;
  localparam logic [15:0] ADDR_ENGINE_RATE = 16'h40EB;
  localparam logic [15:0] ADDR_SERIAL_RATE = 16'h40F8;
  // Clock configuration fields
  localparam int CFG_EN_BIT = 0;
  localparam int CFG_FREQ_LSB = 1;
  localparam int CFG_SRC_BIT = 3;
  localparam logic [7:0] CFG_RESET = 8'h00;
  localparam logic [7:0] CFG_MASK = 8'h0F;
  // PLL configuration fields
  localparam int PLL_EN_BIT = 0;
  localparam int PLL_LOCK_BIT = 1;
  localparam int PLL_FRAC_BIT = 2;
  localparam int PLL_X_LSB = 9;
  localparam int PLL_R_LSB = 11;
  localparam int PLL_N_LSB = 16;
  localparam int PLL_M_LSB = 32;
  localparam logic [47:0] PLL_RESET = 48'h0000_0000_0000;
  localparam logic [15:0] PLL_DEN_INT = 16'h0001;
  // Rate registers
  localparam logic [7:0] RATE_RESET = 8'h00;
  localparam logic [7:0] CONV_MASK = 8'h07;
  localparam logic [7:0] ENGINE_MASK = 8'h0F;
  localparam logic [7:0] SERIAL_MASK = 8'h07;
  // Core clock divider
  localparam int CORE_RATIO = 256;
  localparam logic [1:0] PLL_DIV = 2'h3;
  // Sample rate codes
  localparam logic [3:0] RATE_X1 = 4'h0;
  localparam logic [3:0] RATE_D6 = 4'h1;
  localparam logic [3:0] RATE_D4 = 4'h2;
  localparam logic [3:0] RATE_D3 = 4'h3;
  localparam logic [3:0] RATE_D2 = 4'h4;
  localparam logic [3:0] RATE_D1P5 = 4'h5;
  localparam logic [3:0] RATE_X2 = 4'h6;
  // Core ticks per sample
  localparam logic [10:0] PER_X1 = 11'(CORE_RATIO);
  localparam logic [10:0] PER_D6 = 11'(6 * CORE_RATIO);
  localparam logic [10:0] PER_D4 = 11'(4 * CORE_RATIO);
  localparam logic [10:0] PER_D3 = 11'(3 * CORE_RATIO);
  localparam logic [10:0] PER_D2 = 11'(2 * CORE_RATIO);
  localparam logic [10:0] PER_D1P5 = 11'(3 * CORE_RATIO / 2);
  localparam logic [10:0] PER_X2 = 11'(CORE_RATIO / 2);
  localparam int MIN_PERIOD = CORE_RATIO / 2;
endpackage

// ---- logic/core_clock_ctrl.sv ----
// Core clock generation, gating and sample rate control
`timescale 1ns/1ps
// Operation
// - Core clock runs at 256 times base rate from a divider while enabled and, with PLL source, locked.
// - Direct source divides by 1, 2, 3 or 4 per input rate.
// - PLL output is 1024 times base; divider forced to four.
// - Clock config bit 3 picks master pin (0) or PLL (1).
// - Bits 2:1 give input rate 256..1024 times base; reset 00.
// - Clock config bit 0 enables core clock; reset value disabled.
// - Converter, serial and engine clocks come from core clock only.
// - Converter config bits 2:0 set converter sample rate ratio.
// - Engine rate register bits 3:0 set engine frame rate.
// - Serial rate register bits 2:0 set serial port rate.
// - Supported scalings are 1, 6, 4, 3, 2, 1.5 and 0.5.
// - A sample spans the rate scaling times 256 core clock cycles.
// - Integer PLL mode uses the integer factor, ignoring N and M.
// - Fractional mode multiplies by integer plus N over M.
// - Core clock stays off until PLL lock; lock bit readable.
// - Before enable and lock only clock and PLL config accessible.
module core_clock_ctrl
  import clk_ctrl_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Register port
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_addr,
  input wire logic [47:0] reg_wdata,
  output logic [47:0] reg_rdata,
  output logic reg_rvalid,
  output logic reg_refused,
  // PLL analogue side
  input wire logic pll_clk_pin,
  input wire logic pll_lock_pin,
  output logic pll_enable,
  output logic pll_frac_mode,
  output logic [1:0] pll_in_div,
  output logic [3:0] pll_int,
  output logic [15:0] pll_num,
  output logic [15:0] pll_den,
  // Core clock and sample strobes
  output logic core_tick,
  output logic core_running,
  output logic conv_fs_tick,
  output logic engine_fs_tick,
  output logic serial_fs_tick
);
  typedef enum logic [2:0] {
    ST_OFF = 3'b001,
    ST_WAIT_LOCK = 3'b010,
    ST_RUN = 3'b100
  } core_state_e;

  typedef struct packed {
    core_state_e state;
    logic [7:0] cfg;
    logic [47:0] pll;
    logic [7:0] conv;
    logic [7:0] eng;
    logic [7:0] ser;
    logic src_act;
    logic [1:0] div_act;
    logic [1:0] cnt;
    logic pll_lvl;
    logic tick;
    logic [47:0] rdata;
    logic rvalid;
    logic refused;
    logic pll_en;
    logic frac;
    logic [1:0] xdiv;
    logic [3:0] r_int;
    logic [15:0] num;
    logic [15:0] den;
  } ctrl_s;

  localparam ctrl_s CTRL_RESET = '{
    state: ST_OFF,
    cfg: CFG_RESET,
    pll: PLL_RESET,
    conv: RATE_RESET,
    eng: RATE_RESET,
    ser: RATE_RESET,
    src_act: 1'b0,
    div_act: 2'h0,
    cnt: 2'h0,
    pll_lvl: 1'b0,
    tick: 1'b0,
    rdata: 48'h0000_0000_0000,
    rvalid: 1'b0,
    refused: 1'b0,
    pll_en: 1'b0,
    frac: 1'b0,
    xdiv: 2'h0,
    r_int: 4'h0,
    num: 16'h0000,
    den: PLL_DEN_INT
  };

  ctrl_s st_r;
  ctrl_s st_nxt;
  logic pll_clk_s;
  logic lock_s;
  logic pll_edge;
  logic src_tick;
  logic gate;
  logic want_pll;
  logic access_ok;
  logic is_rate;
  logic [1:0] div_sel;

  sync2 #(.W(2)) u_sync (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .d({pll_clk_pin, pll_lock_pin}),
    .q({pll_clk_s, lock_s})
  );

  // Either edge of the PLL clock counts as one PLL cycle
  assign pll_edge = pll_clk_s != st_r.pll_lvl;
  assign src_tick = st_r.src_act ? pll_edge : 1'b1;
  assign gate = st_r.state == ST_RUN;
  assign want_pll = st_r.cfg[CFG_SRC_BIT];
  assign access_ok = st_r.cfg[CFG_EN_BIT] && (!want_pll || lock_s);
  assign is_rate = reg_addr == ADDR_CONV_CFG
                || reg_addr == ADDR_ENGINE_RATE
                || reg_addr == ADDR_SERIAL_RATE;
  // PLL delivers 1024x base, so divide by four
  assign div_sel = want_pll ? PLL_DIV
                 : st_r.cfg[CFG_FREQ_LSB +: 2];

  always_comb begin
    st_nxt = st_r;
    st_nxt.tick = 1'b0;
    st_nxt.rvalid = 1'b0;
    st_nxt.refused = 1'b0;
    st_nxt.pll_lvl = pll_clk_s;

    // Enable and lock sequencing
    case (st_r.state)
      ST_OFF: begin
        if (st_r.cfg[CFG_EN_BIT]) begin
          st_nxt.state = (want_pll && !lock_s) ? ST_WAIT_LOCK : ST_RUN;
        end
      end
      ST_WAIT_LOCK: begin
        if (!st_r.cfg[CFG_EN_BIT]) begin
          st_nxt.state = ST_OFF;
        end else if (lock_s || !want_pll) begin
          st_nxt.state = ST_RUN;
        end
      end
      ST_RUN: begin
        if (!st_r.cfg[CFG_EN_BIT]) begin
          st_nxt.state = ST_OFF;
        end else if (want_pll && !lock_s) begin
          st_nxt.state = ST_WAIT_LOCK;
        end
      end
      default: st_nxt.state = ST_OFF;
    endcase

    // Divider reloads source and ratio only at a period boundary
    if (!gate) begin
      st_nxt.cnt = 2'h0;
      st_nxt.src_act = want_pll;
      st_nxt.div_act = div_sel;
    end else if (src_tick) begin
      if (st_r.cnt == st_r.div_act) begin
        st_nxt.cnt = 2'h0;
        st_nxt.tick = 1'b1;
        st_nxt.src_act = want_pll;
        st_nxt.div_act = div_sel;
      end else begin
        st_nxt.cnt = st_r.cnt + 2'h1;
      end
    end

    // Register writes
    if (reg_wr) begin
      if (is_rate && !access_ok) begin
        st_nxt.refused = 1'b1;
      end else begin
        case (reg_addr)
          ADDR_CLOCK_CFG: st_nxt.cfg = reg_wdata[7:0] & CFG_MASK;
          ADDR_PLL_CFG: begin
            // Whole 48-bit word taken at once
            st_nxt.pll = reg_wdata;
            st_nxt.pll[PLL_LOCK_BIT] = 1'b0;
            st_nxt.pll_en = reg_wdata[PLL_EN_BIT];
            st_nxt.frac = reg_wdata[PLL_FRAC_BIT];
            st_nxt.xdiv = reg_wdata[PLL_X_LSB +: 2];
            st_nxt.r_int = reg_wdata[PLL_R_LSB +: 4];
            if (reg_wdata[PLL_FRAC_BIT]) begin
              st_nxt.num = reg_wdata[PLL_N_LSB +: 16];
              st_nxt.den = reg_wdata[PLL_M_LSB +: 16];
            end else begin
              st_nxt.num = 16'h0000;
              st_nxt.den = PLL_DEN_INT;
            end
          end
          ADDR_CONV_CFG: st_nxt.conv = reg_wdata[7:0] & CONV_MASK;
          ADDR_ENGINE_RATE: st_nxt.eng = reg_wdata[7:0] & ENGINE_MASK;
          ADDR_SERIAL_RATE: st_nxt.ser = reg_wdata[7:0] & SERIAL_MASK;
          default: st_nxt.cfg = st_r.cfg;
        endcase
      end
    end

    // Register reads
    if (reg_rd) begin
      st_nxt.rvalid = 1'b1;
      st_nxt.rdata = 48'h0000_0000_0000;
      if (is_rate && !access_ok) begin
        st_nxt.refused = 1'b1;
      end else begin
        case (reg_addr)
          ADDR_CLOCK_CFG: st_nxt.rdata[7:0] = st_r.cfg;
          ADDR_PLL_CFG: begin
            st_nxt.rdata = st_r.pll;
            st_nxt.rdata[PLL_LOCK_BIT] = lock_s;
          end
          ADDR_CONV_CFG: st_nxt.rdata[7:0] = st_r.conv;
          ADDR_ENGINE_RATE: st_nxt.rdata[7:0] = st_r.eng;
          ADDR_SERIAL_RATE: st_nxt.rdata[7:0] = st_r.ser;
          default: st_nxt.rdata = 48'h0000_0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      st_r <= CTRL_RESET;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Rate strobes all count core ticks
  rate_gen #(.CNT_W(11)) u_conv_rate (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .run(gate),
    .core_tick(st_r.tick),
    .rate_code({1'b0, st_r.conv[2:0]}),
    .fs_tick(conv_fs_tick)
  );
  rate_gen #(.CNT_W(11)) u_engine_rate (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .run(gate),
    .core_tick(st_r.tick),
    .rate_code(st_r.eng[3:0]),
    .fs_tick(engine_fs_tick)
  );
  rate_gen #(.CNT_W(11)) u_serial_rate (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .run(gate),
    .core_tick(st_r.tick),
    .rate_code({1'b0, st_r.ser[2:0]}),
    .fs_tick(serial_fs_tick)
  );

  assign reg_rdata = st_r.rdata;
  assign reg_rvalid = st_r.rvalid;
  assign reg_refused = st_r.refused;
  assign pll_enable = st_r.pll_en;
  assign pll_frac_mode = st_r.frac;
  assign pll_in_div = st_r.xdiv;
  assign pll_int = st_r.r_int;
  assign pll_num = st_r.num;
  assign pll_den = st_r.den;
  assign core_tick = st_r.tick;
  assign core_running = gate;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  // State leaves RUN one edge after the clear, the last tick on that same edge
  property p_off_when_disabled;
    !st_r.cfg[CFG_EN_BIT] |-> ##2 !core_tick;
  endproperty
  a_off_when_disabled: assert property (p_off_when_disabled)
    else $error("core clock ticked while disabled");
  property p_pll_div4;
    gate && st_r.src_act |-> st_r.div_act == PLL_DIV;
  endproperty
  a_pll_div4: assert property (p_pll_div4)
    else $error("PLL source not divided by four");
  property p_direct_div1;
    gate && !st_r.src_act && st_r.div_act == 2'h0 |=> core_tick;
  endproperty
  a_direct_div1: assert property (p_direct_div1)
    else $error("direct divide by one missed a tick");
  property p_lock_gate;
    want_pll && !lock_s && !gate |=> !core_tick;
  endproperty
  a_lock_gate: assert property (p_lock_gate)
    else $error("core clock ran before lock");
  property p_refuse;
    reg_wr && is_rate && !access_ok
      |=> reg_refused && $stable(st_r.conv) && $stable(st_r.eng);
  endproperty
  a_refuse: assert property (p_refuse)
    else $error("locked-out write was accepted");
  sequence s_pll_int_write;
    reg_wr && reg_addr == ADDR_PLL_CFG && !reg_wdata[PLL_FRAC_BIT];
  endsequence
  property p_int_mode;
    s_pll_int_write |=> !pll_frac_mode && pll_num == 16'h0000
      && pll_den == PLL_DEN_INT;
  endproperty
  a_int_mode: assert property (p_int_mode)
    else $error("integer mode kept fraction");
  sequence s_pll_frac_write;
    reg_wr && reg_addr == ADDR_PLL_CFG && reg_wdata[PLL_FRAC_BIT];
  endsequence
  property p_frac_mode;
    s_pll_frac_write |=> pll_frac_mode
      && pll_num == $past(reg_wdata[PLL_N_LSB +: 16])
      && pll_den == $past(reg_wdata[PLL_M_LSB +: 16]);
  endproperty
  a_frac_mode: assert property (p_frac_mode)
    else $error("fractional mode values not applied");
  property p_cfg_read;
    reg_rd && reg_addr == ADDR_CLOCK_CFG && !reg_wr
      |=> reg_rvalid && reg_rdata[7:0] == $past(st_r.cfg);
  endproperty
  a_cfg_read: assert property (p_cfg_read)
    else $error("clock config read back wrong");
endmodule

// ---- logic/rate_gen.sv ----
// Sample strobe generator counting core clock ticks
`timescale 1ns/1ps
module rate_gen
  import clk_ctrl_pkg::*;
#(
  parameter int CNT_W = 11
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Core clock
  input wire logic run,
  input wire logic core_tick,
  // Rate select and strobe
  input wire logic [3:0] rate_code,
  output logic fs_tick
);
  if (CNT_W < 11) begin : g_chk
    $error("rate_gen: CNT_W too small for the longest period");
  end

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] per;
    logic tick;
  } rate_s;
  rate_s st_r;
  rate_s st_nxt;

  function automatic logic [CNT_W-1:0] period(input logic [3:0] c);
    logic [10:0] p;
    p = PER_X1;
    case (c)
      RATE_D6: p = PER_D6;
      RATE_D4: p = PER_D4;
      RATE_D3: p = PER_D3;
      RATE_D2: p = PER_D2;
      RATE_D1P5: p = PER_D1P5;
      RATE_X2: p = PER_X2;
      default: p = PER_X1;
    endcase
    return CNT_W'(p);
  endfunction

  // New rate takes effect only at a sample boundary
  always_comb begin
    st_nxt = st_r;
    st_nxt.tick = 1'b0;
    if (!run) begin
      st_nxt.cnt = '0;
      st_nxt.per = period(rate_code);
    end else if (core_tick) begin
      if (st_r.cnt == st_r.per - CNT_W'(1)) begin
        st_nxt.cnt = '0;
        st_nxt.tick = 1'b1;
        st_nxt.per = period(rate_code);
      end else begin
        st_nxt.cnt = st_r.cnt + CNT_W'(1);
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign fs_tick = st_r.tick;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  property p_fs_gap;
    fs_tick |=> !fs_tick [*8];
  endproperty
  a_fs_gap: assert property (p_fs_gap)
    else $error("sample strobes too close");

  property p_fs_from_core;
    fs_tick |-> $past(core_tick) && st_r.cnt == '0;
  endproperty
  a_fs_from_core: assert property (p_fs_from_core)
    else $error("sample strobe without core tick");
endmodule

// ---- logic/sync2.sv ----
// Two flip-flop synchroniser
`timescale 1ns/1ps
module sync2 #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Data
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } sync_s;
  sync_s st_r;
  sync_s st_nxt;

  always_comb begin
    st_nxt.s1 = d;
    st_nxt.s2 = st_r.s1;
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign q = st_r.s2;
endmodule

// ---- test/core_clock_and_sample_rate_control_tb_top.sv ----
// Testbench for core clock generation and sample rate control
`timescale 1ns/1ps
module core_clock_and_sample_rate_control_tb_top;
  import clk_ctrl_pkg::*;
  logic sys_clk, rst_n, reg_wr, reg_rd, reg_rvalid, reg_refused;
  logic [15:0] reg_addr;
  logic [47:0] reg_wdata, reg_rdata;
  logic pll_clk_pin, pll_lock_pin, pll_enable, pll_frac_mode;
  logic [1:0] pll_in_div;
  logic [3:0] pll_int;
  logic [15:0] pll_num, pll_den;
  logic core_tick, core_running;
  logic conv_fs_tick, engine_fs_tick, serial_fs_tick;
  int err_total, check_count;

  core_clock_ctrl u_dut (
    .sys_clk, .rst_n, .reg_wr, .reg_rd, .reg_addr, .reg_wdata,
    .reg_rdata, .reg_rvalid, .reg_refused, .pll_clk_pin,
    .pll_lock_pin, .pll_enable, .pll_frac_mode, .pll_in_div,
    .pll_int, .pll_num, .pll_den, .core_tick, .core_running,
    .conv_fs_tick, .engine_fs_tick, .serial_fs_tick
  );
  pll_source_model u_pll (.pll_enable, .pll_clk_pin, .pll_lock_pin);

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  task automatic summarize();
    if (err_total == 0 && check_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic check(input logic [47:0] got, input logic [47:0] exp);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic idle(input int k);
    repeat (k) @(posedge sys_clk);
    #1;
  endtask

  task automatic wr(input logic [15:0] a, input logic [47:0] d);
    @(posedge sys_clk);
    #1;
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(posedge sys_clk);
    #1;
    reg_wr = 1'b0;
  endtask

  task automatic rd(input logic [15:0] a, output logic [47:0] q,
                    output logic f);
    @(posedge sys_clk);
    #1;
    reg_rd = 1'b1;
    reg_addr = a;
    @(posedge sys_clk);
    #1;
    reg_rd = 1'b0;
    check(reg_rvalid, 1'b1);
    q = reg_rdata;
    f = reg_refused;
  endtask

  function automatic logic pick(input int s);
    case (s)
      0: return core_tick;
      1: return conv_fs_tick;
      2: return engine_fs_tick;
      default: return serial_fs_tick;
    endcase
  endfunction

  // Cycles up to and including the next strobe of the chosen output
  task automatic gap(input int s, input int lim, output int n);
    n = 0;
    do begin
      @(posedge sys_clk);
      #1;
      n++;
    end while (pick(s) !== 1'b1 && n < lim);
  endtask

  // Skips the two periods after a new setting lands
  task automatic meas(input int s, output int n);
    repeat (3) gap(s, 4000, n);
  endtask

  function automatic logic [47:0] pllw(input logic frac);
    return {16'h007D, 16'h000C, 1'b0, 4'h4, 2'h1, 6'h00, frac, 2'b01};
  endfunction

  task automatic t_reset();
    logic [47:0] q;
    logic f;
    rd(ADDR_CLOCK_CFG, q, f);
    check(q, 48'h0);
    rd(ADDR_PLL_CFG, q, f);
    check(q, 48'h0);
    check(pll_den, 16'h0001);
    check(core_running, 1'b0);
    rd(16'h4001, q, f);
    check(q, 48'h0);
    check(48'(f), 48'h0);
  endtask

  task automatic t_refuse();
    logic [47:0] q;
    logic f;
    wr(ADDR_CONV_CFG, 48'h04);
    check(reg_refused, 1'b1);
    rd(ADDR_CONV_CFG, q, f);
    check(q, 48'h0);
    check(48'(f), 48'h1);
  endtask

  task automatic t_direct();
    logic [47:0] q;
    logic f;
    int n;
    for (int d = 0; d < 4; d++) begin
      wr(ADDR_CLOCK_CFG, 48'(d * 2 + 1));
      meas(0, n);
      check(48'(n), 48'(d + 1));
    end
    check(core_running, 1'b1);
    rd(ADDR_CLOCK_CFG, q, f);
    check(q, 48'h07);
  endtask

  task automatic t_rates();
    int per[7] = '{256, 1536, 1024, 768, 512, 384, 128};
    int n;
    wr(ADDR_CLOCK_CFG, 48'h01);
    for (int c = 0; c < 7; c++) begin
      wr(ADDR_CONV_CFG, 48'(c));
      meas(1, n);
      check(48'(n), 48'(per[c]));
    end
    wr(ADDR_ENGINE_RATE, 48'h02);
    meas(2, n);
    check(48'(n), 48'd1024);
    wr(ADDR_SERIAL_RATE, 48'h06);
    meas(3, n);
    check(48'(n), 48'd128);
    meas(2, n);
    check(48'(n), 48'd1024);
    wr(ADDR_CLOCK_CFG, 48'h03);
    meas(1, n);
    check(48'(n), 48'd256);
    wr(ADDR_ENGINE_RATE, 48'h06);
    meas(2, n);
    check(48'(n), 48'd256);
  endtask

  task automatic t_pll();
    logic [47:0] q;
    logic f;
    int n;
    int t;
    wr(ADDR_CLOCK_CFG, 48'h00);
    wr(ADDR_PLL_CFG, pllw(1'b0));
    idle(2);
    check({pll_num, pll_den}, 32'h0000_0001);
    check({pll_int, pll_in_div, pll_enable}, 7'h23);
    wr(ADDR_CLOCK_CFG, 48'h09);
    idle(2);
    check(core_running, 1'b0);
    wr(ADDR_CONV_CFG, 48'h03);
    check(reg_refused, 1'b1);
    q = 48'h0;
    for (int i = 0; i < 400 && q[1] !== 1'b1; i++) begin
      rd(ADDR_PLL_CFG, q, f);
    end
    check(q[1], 1'b1);
    repeat (2) gap(0, 100, n);
    t = 0;
    repeat (4) begin
      gap(0, 100, n);
      t += n;
    end
    check(48'(t >= 39 && t <= 41), 48'h1);
    rd(ADDR_CONV_CFG, q, f);
    check(q, 48'h6);
    check(48'(f), 48'h0);
    wr(ADDR_PLL_CFG, pllw(1'b1));
    idle(2);
    check({pll_num, pll_den}, 32'h000C_007D);
    check(pll_frac_mode, 1'b1);
    wr(ADDR_CLOCK_CFG, 48'h08);
    idle(12);
    gap(0, 50, n);
    check(48'(n), 48'd50);
    check(core_running, 1'b0);
  endtask

  initial begin
    #1_000_000;
    err_total++;
    summarize();
  end

  initial begin
    err_total = 0;
    check_count = 0;
    rst_n = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 16'h0000;
    reg_wdata = 48'h0;
    repeat (8) @(posedge sys_clk);
    #1;
    rst_n = 1'b1;
    t_reset();
    t_refuse();
    t_direct();
    t_rates();
    t_pll();
    summarize();
  end
endmodule

// ---- test/pll_source_model.sv ----
// Model of the PLL output clock and lock detector beside the block
`timescale 1ns/1ps
module pll_source_model #(
  parameter int HALF_NS = 25,
  parameter int LOCK_NS = 2000
) (
  // PLL control from the block
  input wire logic pll_enable,
  // PLL clock and lock towards the block
  output logic pll_clk_pin,
  output logic pll_lock_pin
);
  initial begin
    pll_clk_pin = 1'b0;
    pll_lock_pin = 1'b0;
  end
  // Toggles only while enabled, stands still otherwise
  always begin
    wait (pll_enable === 1'b1);
    #(HALF_NS) pll_clk_pin = ~pll_clk_pin;
  end
  // Lock rises a fixed time after enable and drops with it
  always @(pll_enable) begin
    pll_lock_pin = 1'b0;
    if (pll_enable === 1'b1) begin
      #(LOCK_NS) pll_lock_pin = pll_enable;
    end
  end
endmodule
